// [hdlc_defines.vh]
/*
  HDLC de-framer constants: register map, field positions, context
  values, framing bytes and lookup entry layout. Included by bare name.
*/
`ifndef HDLC_DEFINES_VH
`define HDLC_DEFINES_VH

// register map, byte addresses
`define REG_CFG_OFS       3'h0
`define REG_CTX_OFS       3'h4
`define REG_GLOBAL_BIT    11
`define REG_EVT_CNT       12'h800
`define REG_DISCARD_CNT   12'h804
`define REG_OVERRUN_CNT   12'h808
`define REG_CONTROL       12'h80c
`define CTRL_RESET        1'b1

// per-stream configuration word
`define CFG_FMT_R         2:0
`define CFG_CRC           3
`define CFG_STYLE         4
`define CFG_AAL2          5
`define CFG_RANGE_R       10:6
`define CFG_BASE_R        26:11
`define CFG_W             27

// per-stream context word
`define CTX_ONES_R        2:0
`define CTX_HIST_R        10:3
`define CTX_IN            11
`define CTX_ESC           12

// header formats
`define FMT_ONE_ADDR      3'b001
`define FMT_TWO_ADDR_A    3'b010
`define FMT_TWO_ADDR_B    3'b100

// context values that mean "nothing pending"
`define ONES_HUNT         3'b111
`define HIST_EMPTY        8'h01

// byte-oriented framing
`define FLAG_BYTE         8'h7e
`define ESC_BYTE          8'h7d
`define ESC_XOR           8'h20

`define CRC_BYTES         11'd2
`define RANGE_FULL        10'd512

// address lookup entry
`define ENT_CONN_R        15:0
`define ENT_TS_SEL        16
`define ENT_FLUSH         17
`define ENT_TIMEOUT_R     25:18

`endif

// [hdlc_bit_step.v]
/*
  One bit of a bit-oriented HDLC stream: ones count, destuffing,
  flag and abort, byte assembly in a sentinel history field.
  Assumes bits arrive least significant first; combinational.
*/
`timescale 1ns/1ns
`default_nettype none
`include "hdlc_defines.vh"

module hdlc_bit_step
(
  // context in
  input  wire [2:0] ones,
  input  wire [7:0] hist,
  input  wire       rx_bit,
  // context out and results
  output reg  [2:0] next_ones,
  output reg  [7:0] next_hist,
  output reg  [7:0] byte_out,
  output reg        byte_done,
  output reg        flag,
  output reg        abort
);

  integer   i;
  reg [2:0] push_ones;
  reg       push_zero;

  // ones are held back in the counter and only pushed once a zero shows
  // they were data; this keeps flag bits out of the history
  always @*
  begin
    next_ones = ones;
    next_hist = hist;
    byte_out  = 8'h00;
    byte_done = 1'b0;
    flag      = 1'b0;
    abort     = 1'b0;
    push_ones = 3'd0;
    push_zero = 1'b0;
    if (rx_bit)
    begin
      if (ones == 3'd6)
      begin
        next_ones = `ONES_HUNT;                   // [RULE_03]
        next_hist = `HIST_EMPTY;
        abort     = 1'b1;
      end
      else if (ones != `ONES_HUNT)
        next_ones = ones + 3'd1;                  // [RULE_03]
    end
    else
    begin
      next_ones = 3'd0;
      case (ones)
        3'd7:
          next_hist = `HIST_EMPTY;
        3'd6:
        begin
          flag      = 1'b1;
          next_hist = `HIST_EMPTY;
        end
        3'd5:
          push_ones = 3'd5;                       // stuffed zero dropped
        default:
        begin
          push_ones = ones;
          push_zero = 1'b1;
        end
      endcase
    end
    // at most five bits are pushed, so at most one byte completes
    for (i = 0; i < 7; i = i + 1)
    begin
      if ((i < push_ones) || ((i == push_ones) && push_zero))
      begin
        if (next_hist[7])                         // [RULE_05]
        begin
          byte_done = 1'b1;
          byte_out  = reverse8({next_hist[6:0], (i < push_ones)});
          next_hist = `HIST_EMPTY;
        end
        else
          next_hist = {next_hist[6:0], (i < push_ones)};
      end
    end
  end

  function [7:0] reverse8;
    input [7:0] v;
    integer k;
    begin
      for (k = 0; k < 8; k = k + 1)
        reverse8[k] = v[7 - k];
    end
  endfunction

endmodule

`default_nettype wire

// [hdlc_deframe.v]
/*
  HDLC de-framer with per-stream context and address lookup.
  TDM bytes arrive tagged with a stream number; each finished
  packet is checked; one that passes is looked up in SSRAM and
  posted as an event unless its connection is zero.
  CRC bytes are only stripped, never verified.
  Assumes TDM pins stable three clocks around a rising valid,
  and an SSRAM port on this clock that answers each read.
*/
// Design decisions made here: the register addresses and the strobed register port.
// Functional notes
// RULE_01: header code 000 plain, 001 one address byte, 010/100 two plus control.
// RULE_02: with CRC bit set, last 16 bits of each packet are the CRC.
// RULE_03: keep per-stream count of recent consecutive one bits.
// RULE_04: software sets the ones counter to 111 before using a stream.
// RULE_05: partial byte kept in history with sentinel marking pending bit count.
// RULE_06: software sets history to 00000001 before using a stream.
// RULE_07: each completed packet posts an event to the assembly queue; here only one that passes the checks and has a nonzero connection.
// RULE_08: valid address count per stream is 16 to 512 in steps of 16.
// RULE_09: lookup table base counts 64-byte units in SSRAM.
// RULE_10: range 00000 means 0..511; n otherwise means 0..16n-1.
// RULE_11: lookup descriptor is indexed by the stream number itself.
// RULE_12: lookup table is read every time a packet completes; here only after the header, length and range checks pass.
// RULE_13: connection base of zero marks the address invalid; packet dropped.
// RULE_14: RTP timestamp used as received, or added to the bus timestamp.
// RULE_15: AAL2 cell fill timeout in frames travels with the packet.
// RULE_16: AAL2 flush bit makes this packet start a fresh cell.
// RULE_17: two-byte addresses use the low nine bits; one byte gives 256.
// RULE_18: framing style bit selects bit-oriented or byte-oriented framing.
// RULE_19: an address beyond the configured range drops the packet.
`timescale 1ns/1ns
`default_nettype none
`include "hdlc_defines.vh"

module hdlc_deframe
#(
  parameter SW    = 4,
  parameter LEN_W = 11
)
(
  // clock and reset
  input  wire             clk,
  input  wire             rst,
  // register port
  input  wire [11:0]      reg_addr,
  input  wire [31:0]      reg_wdata,
  input  wire             reg_wr,
  input  wire             reg_rd,
  output reg  [31:0]      reg_rdata,
  // tdm byte pins
  input  wire             tdm_valid,
  input  wire [SW-1:0]    tdm_stream,
  input  wire [7:0]       tdm_data,
  // external lookup memory
  output reg              ssram_rd,
  output reg  [23:0]      ssram_addr,
  input  wire             ssram_valid,
  input  wire [31:0]      ssram_rdata,
  // timestamps
  input  wire [31:0]      bus_timestamp,
  input  wire [31:0]      pkt_timestamp,
  // assembly event
  output reg              evt_valid,
  output reg  [SW-1:0]    evt_stream,
  output reg  [15:0]      evt_conn,
  output reg  [LEN_W-1:0] evt_len,
  output reg  [31:0]      evt_timestamp,
  output reg              evt_aal2,
  output reg              evt_flush,
  output reg  [7:0]       evt_timeout
);

  localparam STREAMS  = 1 << SW;
  localparam ST_IDLE  = 4'b0001;
  localparam ST_STEP  = 4'b0010;
  localparam ST_CHECK = 4'b0100;
  localparam ST_WAIT  = 4'b1000;

  // per-stream configuration and context
  reg [`CFG_W-1:0] cfg_mem  [0:STREAMS-1];
  reg [2:0]        ones_mem [0:STREAMS-1];
  reg [7:0]        hist_mem [0:STREAMS-1];
  reg [1:0]        hbc_mem  [0:STREAMS-1];
  reg [8:0]        addr_mem [0:STREAMS-1];
  reg [LEN_W-1:0]  len_mem  [0:STREAMS-1];
  reg [STREAMS-1:0] in_frame;
  reg [STREAMS-1:0] esc_pend;

  // pin synchronisers
  reg              v_s1, v_s2, v_s3;
  reg [SW-1:0]     st_s1, st_s2;
  reg [7:0]        d_s1, d_s2;
  wire             strobe = v_s2 & ~v_s3;

  // working copy of one stream
  reg [3:0]        state;
  reg [SW-1:0]     w_stream;
  reg [7:0]        w_data;
  reg [2:0]        bit_idx;
  reg [2:0]        w_ones;
  reg [7:0]        w_hist;
  reg              w_in, w_esc, resume;
  reg [1:0]        w_hbc;
  reg [8:0]        w_addr;
  reg [LEN_W-1:0]  w_len;

  // captured completed packet
  reg [8:0]        c_addr;
  reg [1:0]        c_hbc;
  reg [LEN_W-1:0]  c_len;

  reg              enable;
  reg [31:0]       evt_cnt, discard_cnt, overrun_cnt;

  wire [`CFG_W-1:0] w_cfg = cfg_mem[w_stream];  // [RULE_11]
  wire              byte_mode = w_cfg[`CFG_STYLE];
  wire [1:0]        hdr_len = hdr_bytes(w_cfg[`CFG_FMT_R]);
  wire [LEN_W-1:0]  crc_len = w_cfg[`CFG_CRC] ? `CRC_BYTES : {LEN_W{1'b0}};
  wire              last_step = byte_mode | (bit_idx == 3'd7);

  wire [2:0] s_ones;
  wire [7:0] s_hist, s_byte;
  wire       s_done, s_flag, s_abort;

  hdlc_bit_step u_bit_step
  (
    .ones      (w_ones),
    .hist      (w_hist),
    .rx_bit    (w_data[bit_idx]),
    .next_ones (s_ones),
    .next_hist (s_hist),
    .byte_out  (s_byte),
    .byte_done (s_done),
    .flag      (s_flag),
    .abort     (s_abort)
  );

  function [1:0] hdr_bytes;
    input [2:0] fmt;
    begin
      case (fmt)                                  // [RULE_01]
        `FMT_ONE_ADDR:   hdr_bytes = 2'd1;
        `FMT_TWO_ADDR_A: hdr_bytes = 2'd3;
        `FMT_TWO_ADDR_B: hdr_bytes = 2'd3;
        default:         hdr_bytes = 2'd0;        // plain; reserved as plain
      endcase
    end
  endfunction

  // number of valid addresses for a range code
  function [9:0] range_limit;
    input [4:0] code;
    begin
      if (code == 5'd0)
        range_limit = `RANGE_FULL;                // [RULE_10]
      else
        range_limit = {1'b0, code, 4'h0};         // [RULE_08] [RULE_10]
    end
  endfunction

  // one framing step on the working copy
  reg [2:0]       next_ones;
  reg [7:0]       next_hist, dbyte;
  reg             next_in, next_esc, complete, got, flag, abort;
  reg [1:0]       next_hbc;
  reg [8:0]       next_addr;
  reg [LEN_W-1:0] next_len;

  always @*
  begin
    next_ones = w_ones;
    next_hist = w_hist;
    next_in   = w_in;
    next_esc  = w_esc;
    next_hbc  = w_hbc;
    next_addr = w_addr;
    next_len  = w_len;
    complete  = 1'b0;
    got       = 1'b0;
    flag      = 1'b0;
    abort     = 1'b0;
    dbyte     = 8'h00;
    if (byte_mode)                                // [RULE_18]
    begin
      if (w_esc)
      begin
        next_esc = 1'b0;
        if (w_data == `FLAG_BYTE)
          abort = 1'b1;
        else
        begin
          got   = 1'b1;
          dbyte = w_data ^ `ESC_XOR;
        end
      end
      else if (w_data == `FLAG_BYTE)
        flag = 1'b1;
      else if (w_data == `ESC_BYTE)
        next_esc = 1'b1;
      else
      begin
        got   = 1'b1;
        dbyte = w_data;
      end
    end
    else
    begin
      next_ones = s_ones;                         // [RULE_03]
      next_hist = s_hist;                         // [RULE_05]
      flag      = s_flag;
      abort     = s_abort;
      got       = s_done;
      dbyte     = s_byte;
    end
    if (abort)
      next_in = 1'b0;
    else if (flag)
    begin
      complete  = w_in & ((w_hbc != 2'd0) | (w_len != {LEN_W{1'b0}}));
      next_in   = 1'b1;
      next_hbc  = 2'd0;
      next_addr = 9'd0;
      next_len  = {LEN_W{1'b0}};
    end
    else if (got & w_in)
    begin
      if (w_hbc < hdr_len)
      begin
        if (hdr_len == 2'd1)
          next_addr = {1'b0, dbyte};              // [RULE_17]
        else if (w_hbc == 2'd0)
          next_addr = {dbyte[0], 8'h00};          // [RULE_17]
        else if (w_hbc == 2'd1)
          next_addr = {w_addr[8], dbyte};
        next_hbc = w_hbc + 2'd1;
      end
      else if (w_len != {LEN_W{1'b1}})
        next_len = w_len + {{(LEN_W-1){1'b0}}, 1'b1};
    end
  end

  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      v_s1  <= 1'b0;
      v_s2  <= 1'b0;
      v_s3  <= 1'b0;
      st_s1 <= {SW{1'b0}};
      st_s2 <= {SW{1'b0}};
      d_s1  <= 8'h00;
      d_s2  <= 8'h00;
    end
    else
    begin
      v_s1  <= tdm_valid;
      v_s2  <= v_s1;
      v_s3  <= v_s2;
      st_s1 <= tdm_stream;
      st_s2 <= st_s1;
      d_s1  <= tdm_data;
      d_s2  <= d_s1;
    end
  end

  // context memories: software init and engine write-back share a port
  always @(posedge clk)
  begin
    if (reg_wr && !reg_addr[`REG_GLOBAL_BIT])
    begin
      if (reg_addr[2:0] == `REG_CFG_OFS)
        cfg_mem[reg_addr[SW+2:3]] <= reg_wdata[`CFG_W-1:0];
      else if (reg_addr[2:0] == `REG_CTX_OFS)
      begin
        ones_mem[reg_addr[SW+2:3]] <= reg_wdata[`CTX_ONES_R];
        hist_mem[reg_addr[SW+2:3]] <= reg_wdata[`CTX_HIST_R];
        hbc_mem[reg_addr[SW+2:3]]  <= 2'd0;
        addr_mem[reg_addr[SW+2:3]] <= 9'd0;
        len_mem[reg_addr[SW+2:3]]  <= {LEN_W{1'b0}};
      end
    end
    else if (state == ST_STEP && last_step)
    begin
      ones_mem[w_stream] <= next_ones;            // [RULE_03]
      hist_mem[w_stream] <= next_hist;            // [RULE_05]
      hbc_mem[w_stream]  <= next_hbc;
      addr_mem[w_stream] <= next_addr;
      len_mem[w_stream]  <= next_len;
    end
  end

  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      state       <= ST_IDLE;
      in_frame    <= {STREAMS{1'b0}};
      esc_pend    <= {STREAMS{1'b0}};
      w_stream    <= {SW{1'b0}};
      w_data      <= 8'h00;
      bit_idx     <= 3'd0;
      w_ones      <= `ONES_HUNT;
      w_hist      <= `HIST_EMPTY;
      w_in        <= 1'b0;
      w_esc       <= 1'b0;
      w_hbc       <= 2'd0;
      w_addr      <= 9'd0;
      w_len       <= {LEN_W{1'b0}};
      resume      <= 1'b0;
      c_addr      <= 9'd0;
      c_hbc       <= 2'd0;
      c_len       <= {LEN_W{1'b0}};
      ssram_rd    <= 1'b0;
      ssram_addr  <= 24'h000000;
      evt_valid   <= 1'b0;
      evt_stream  <= {SW{1'b0}};
      evt_conn    <= 16'h0000;
      evt_len     <= {LEN_W{1'b0}};
      evt_timestamp <= 32'h00000000;
      evt_aal2    <= 1'b0;
      evt_flush   <= 1'b0;
      evt_timeout <= 8'h00;
      evt_cnt     <= 32'h00000000;
      discard_cnt <= 32'h00000000;
      overrun_cnt <= 32'h00000000;
    end
    else
    begin
      ssram_rd  <= 1'b0;
      evt_valid <= 1'b0;
      if (strobe && enable && state != ST_IDLE)
        overrun_cnt <= overrun_cnt + 32'h00000001;
      if (reg_wr && !reg_addr[`REG_GLOBAL_BIT]
          && reg_addr[2:0] == `REG_CTX_OFS)
      begin
        in_frame[reg_addr[SW+2:3]] <= reg_wdata[`CTX_IN];
        esc_pend[reg_addr[SW+2:3]] <= reg_wdata[`CTX_ESC];
      end
      case (state)
        ST_IDLE:
          if (strobe && enable)
          begin
            w_stream <= st_s2;
            w_data   <= d_s2;
            bit_idx  <= 3'd0;
            w_ones   <= ones_mem[st_s2];
            w_hist   <= hist_mem[st_s2];
            w_in     <= in_frame[st_s2];
            w_esc    <= esc_pend[st_s2];
            w_hbc    <= hbc_mem[st_s2];
            w_addr   <= addr_mem[st_s2];
            w_len    <= len_mem[st_s2];
            state    <= ST_STEP;
          end
        ST_STEP:
        begin
          w_ones  <= next_ones;
          w_hist  <= next_hist;
          w_in    <= next_in;
          w_esc   <= next_esc;
          w_hbc   <= next_hbc;
          w_addr  <= next_addr;
          w_len   <= next_len;
          bit_idx <= bit_idx + 3'd1;
          if (last_step)
          begin
            in_frame[w_stream] <= next_in;
            esc_pend[w_stream] <= next_esc;
          end
          resume <= ~last_step;
          if (complete)
          begin
            c_addr <= w_addr;
            c_hbc  <= w_hbc;
            c_len  <= w_len;
            state  <= ST_CHECK;                   // [RULE_12]
          end
          else if (last_step)
            state <= ST_IDLE;
        end
        ST_CHECK:
          // short header, a length that cannot hold the check value, or an
          // address past the table all drop the packet unread
          if (c_hbc != hdr_len || c_len < crc_len      // [RULE_02]
              || {1'b0, c_addr} >= range_limit(w_cfg[`CFG_RANGE_R]))
          begin
            discard_cnt <= discard_cnt + 32'h00000001; // [RULE_19]
            state       <= resume ? ST_STEP : ST_IDLE;
          end
          else
          begin
            ssram_rd   <= 1'b1;
            ssram_addr <= {2'b00, w_cfg[`CFG_BASE_R], 6'h00}    // [RULE_09]
                          + {13'h0000, c_addr, 2'b00};
            state      <= ST_WAIT;
          end
        ST_WAIT:
          if (ssram_valid)
          begin
            if (ssram_rdata[`ENT_CONN_R] == 16'h0000)
              discard_cnt <= discard_cnt + 32'h00000001; // [RULE_13]
            else
            begin
              evt_valid   <= 1'b1;                // [RULE_07]
              evt_cnt     <= evt_cnt + 32'h00000001;
              evt_stream  <= w_stream;
              evt_conn    <= ssram_rdata[`ENT_CONN_R];
              evt_len     <= c_len - crc_len;     // [RULE_02]
              evt_aal2    <= w_cfg[`CFG_AAL2];
              if (!w_cfg[`CFG_AAL2] && ssram_rdata[`ENT_TS_SEL])
                evt_timestamp <= bus_timestamp + pkt_timestamp; // [RULE_14]
              else
                evt_timestamp <= pkt_timestamp;   // [RULE_14]
              evt_flush   <= w_cfg[`CFG_AAL2]     // [RULE_16]
                             & ssram_rdata[`ENT_FLUSH];
              evt_timeout <= w_cfg[`CFG_AAL2] ?
                             ssram_rdata[`ENT_TIMEOUT_R] : 8'h00; // [RULE_15]
            end
            state <= resume ? ST_STEP : ST_IDLE;
          end
        default:
          state <= ST_IDLE;
      endcase
    end
  end

  // register port: control and read-back
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      enable    <= `CTRL_RESET;
      reg_rdata <= 32'h00000000;
    end
    else
    begin
      if (reg_wr && reg_addr == `REG_CONTROL)
        enable <= reg_wdata[0];
      reg_rdata <= 32'h00000000;
      if (reg_rd)
      begin
        if (!reg_addr[`REG_GLOBAL_BIT] && reg_addr[10:SW+3] == 0)
        begin
          if (reg_addr[2:0] == `REG_CFG_OFS)
            reg_rdata <= {5'h00, cfg_mem[reg_addr[SW+2:3]]};
          else if (reg_addr[2:0] == `REG_CTX_OFS)
            reg_rdata <= {19'h00000, esc_pend[reg_addr[SW+2:3]],
                          in_frame[reg_addr[SW+2:3]],
                          hist_mem[reg_addr[SW+2:3]],
                          ones_mem[reg_addr[SW+2:3]]};
        end
        else if (reg_addr == `REG_EVT_CNT)
          reg_rdata <= evt_cnt;
        else if (reg_addr == `REG_DISCARD_CNT)
          reg_rdata <= discard_cnt;
        else if (reg_addr == `REG_OVERRUN_CNT)
          reg_rdata <= overrun_cnt;
        else if (reg_addr == `REG_CONTROL)
          reg_rdata <= {31'h00000000, enable};
      end
    end
  end

endmodule

`default_nettype wire

// [hdlc_deframe_chk.sv]
/*
  Checker of the de-framer's lookup reads and event outputs.
  Assumes one clock and async active-high reset; bound by name.
*/
`timescale 1ns/1ns
`default_nettype none

module hdlc_deframe_chk
#(
  parameter SW    = 4,
  parameter LEN_W = 11
)
(
  // clock and reset
  input wire logic        clk,
  input wire logic        rst,
  // lookup memory
  input wire logic        ssram_rd,
  input wire logic [23:0] ssram_addr,
  input wire logic        ssram_valid,
  input wire logic [31:0] ssram_rdata,
  // timestamps
  input wire logic [31:0] bus_timestamp,
  input wire logic [31:0] pkt_timestamp,
  // event
  input wire logic        evt_valid,
  input wire logic [15:0] evt_conn,
  input wire logic [31:0] evt_timestamp,
  input wire logic        evt_aal2,
  input wire logic        evt_flush,
  input wire logic [7:0]  evt_timeout
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  property p_evt_pulse;
    evt_valid |=> !evt_valid;
  endproperty
  a_evt_pulse: assert property (p_evt_pulse)
    else $error("event pulse too long");
  property p_evt_cause;
    evt_valid |-> $past(ssram_valid);
  endproperty
  a_evt_cause: assert property (p_evt_cause)
    else $error("event without answer");
  property p_conn;
    evt_valid |-> evt_conn == $past(ssram_rdata[15:0]) && evt_conn != 16'h0;
  endproperty
  a_conn: assert property (p_conn)
    else $error("bad connection");
  property p_rd_once;
    ssram_rd |=> !ssram_rd && $stable(ssram_addr);
  endproperty
  a_rd_once: assert property (p_rd_once)
    else $error("read not a pulse");
  property p_align;
    ssram_rd |-> ssram_addr[1:0] == 2'h0;
  endproperty
  a_align: assert property (p_align)
    else $error("address unaligned");
  property p_ts;
    evt_valid && !evt_aal2 |-> evt_timestamp == ($past(ssram_rdata[16]) ?
      $past(bus_timestamp) + $past(pkt_timestamp) : $past(pkt_timestamp));
  endproperty
  a_ts: assert property (p_ts)
    else $error("event timestamp wrong");
  property p_aal2;
    evt_valid && evt_aal2 |-> evt_flush == $past(ssram_rdata[17]) &&
      evt_timeout == $past(ssram_rdata[25:18]);
  endproperty
  a_aal2: assert property (p_aal2)
    else $error("cell options lost");
  property p_rtp_clear;
    evt_valid && !evt_aal2 |-> !evt_flush && evt_timeout == 8'h0;
  endproperty
  a_rtp_clear: assert property (p_rtp_clear)
    else $error("stray cell options");
  property p_hold;
    !evt_valid |-> $stable(evt_conn) && $stable(evt_timestamp);
  endproperty
  a_hold: assert property (p_hold)
    else $error("event fields moved");
endmodule

bind hdlc_deframe hdlc_deframe_chk #(.SW(SW), .LEN_W(LEN_W)) chk_i (
  .clk, .rst, .ssram_rd, .ssram_addr, .ssram_valid, .ssram_rdata,
  .bus_timestamp, .pkt_timestamp, .evt_valid, .evt_conn,
  .evt_timestamp, .evt_aal2, .evt_flush, .evt_timeout);
`default_nettype wire

// [lut_ssram_model.sv]
/*
  External lookup memory: each entry is derived from its word index.
  Assumes one read in flight; answers three clocks after the request.
*/
`timescale 1ns/1ns
`default_nettype none

module lut_ssram_model
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // read port
  input  wire logic        ssram_rd,
  input  wire logic [23:0] ssram_addr,
  output wire logic        ssram_valid,
  output wire logic [31:0] ssram_rdata
);
  reg  [2:0]  pipe;
  reg  [15:0] w;
  wire [31:0] ent;

  // word index doubles as connection so a bad base shows up at once
  assign ent = {6'h0, w[7:0], w[1], w[0], w};
  assign ssram_valid = pipe[2];
  // outside the answer cycle the data must not look valid
  assign ssram_rdata = pipe[2] ? ent : ~ent;

  always @(posedge clk or posedge rst)
    if (rst)
    begin
      pipe <= 3'h0;
      w    <= 16'h0;
    end
    else
    begin
      pipe <= {pipe[1:0], ssram_rd};
      if (ssram_rd)
        w <= ssram_addr[17:2];
    end
endmodule
`default_nettype wire

// [testbench.sv]
/*
  Self-checking bench for the de-framer: table of packets, then escape,
  abort, enable and register cases.
  Assumes the lookup memory model and checker are compiled alongside.
*/
`timescale 1ns/1ns
`default_nettype none

module testbench;
  typedef struct packed {
    logic [3:0]  s;
    logic [2:0]  fmt;
    logic [2:0]  opt;
    logic [4:0]  rng;
    logic [15:0] base;
    logic [7:0]  a0;
    logic [7:0]  a1;
    logic [3:0]  n;
  } row_t;

  reg         clk = 1'b0;
  reg         rst = 1'b1;
  reg  [11:0] reg_addr = 12'h0;
  reg  [31:0] reg_wdata = 32'h0;
  reg         reg_wr = 1'b0;
  reg         reg_rd = 1'b0;
  reg         tdm_valid = 1'b0;
  reg  [3:0]  tdm_stream = 4'h0;
  reg  [7:0]  tdm_data = 8'h0;
  reg  [31:0] bus_timestamp = 32'h10000000;
  reg  [31:0] pkt_timestamp = 32'h00000123;
  wire [31:0] reg_rdata, ssram_rdata, evt_timestamp;
  wire [23:0] ssram_addr;
  wire [15:0] evt_conn;
  wire [10:0] evt_len;
  wire [7:0]  evt_timeout;
  wire [3:0]  evt_stream;
  wire        ssram_rd, ssram_valid, evt_valid, evt_aal2, evt_flush;
  row_t       rows [0:7];
  row_t       r;
  integer     failures = 0, num_checks = 0, n_ev = 0, nok = 0, ndis = 0;
  integer     i, k, n0, addr, idx;
  reg         e;

  always #50 clk = ~clk;
  always @(posedge clk) if (evt_valid === 1'b1) n_ev <= n_ev + 1;

  hdlc_deframe #(.SW(4), .LEN_W(11)) DUT (
    .clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .tdm_valid, .tdm_stream, .tdm_data, .ssram_rd, .ssram_addr,
    .ssram_valid, .ssram_rdata, .bus_timestamp, .pkt_timestamp,
    .evt_valid, .evt_stream, .evt_conn, .evt_len, .evt_timestamp,
    .evt_aal2, .evt_flush, .evt_timeout);

  lut_ssram_model mem (
    .clk, .rst, .ssram_rd, .ssram_addr, .ssram_valid, .ssram_rdata);

  task chk(input [31:0] got, input [31:0] exp, input string what);
    begin
      num_checks = num_checks + 1;
      if (got !== exp)
      begin
        failures = failures + 1;
        $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
      end
    end
  endtask

  task wr(input [11:0] a, input [31:0] d);
    begin
      @(posedge clk);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
    end
  endtask

  task rd(input [11:0] a, input [31:0] exp);
    begin
      @(posedge clk);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 chk(reg_rdata, exp, "read");
    end
  endtask

  // pins need three clocks of setup; the gap covers step time and lookup
  task put(input [7:0] b);
    begin
      @(posedge clk);
      tdm_data <= b;
      repeat (3) @(posedge clk);
      tdm_valid <= 1'b1;
      repeat (3) @(posedge clk);
      tdm_valid <= 1'b0;
      repeat (16) @(posedge clk);
    end
  endtask

  task seq(input [47:0] b, input integer c);
    integer j;
    begin
      for (j = c - 1; j >= 0; j = j - 1) put(b[8*j +: 8]);
    end
  endtask

  task cfg(input row_t q);
    begin
      wr({q.s, 3'h0}, {5'h0, q.base, q.rng, q.opt, q.fmt});
      wr({q.s, 3'h4}, 32'h0000000f);
      tdm_stream <= q.s;
      n0 = n_ev;
    end
  endtask

  task frame(input row_t q);
    integer j;
    begin
      put(8'h7e);
      if (q.fmt == 3'b001) put(q.a0);
      if (q.fmt == 3'b010 || q.fmt == 3'b100) seq({q.a0, q.a1, 8'h03}, 3);
      for (j = 1; j <= q.n; j = j + 1) put(j[7:0]);
      if (q.opt[0]) seq(16'h1122, 2);
      put(8'h7e);
    end
  endtask

  task await(input exp);
    begin
      k = 0;
      while (n_ev == n0 && k < 50)
      begin
        @(posedge clk);
        k = k + 1;
      end
      #1 chk(n_ev - n0, exp, "events");
    end
  endtask

  task test_done;
    begin
      $display("checks %0d failures %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0)
        $display("RESULT: PASS");
      else
        $display("RESULT: FAIL");
      $finish;
    end
  endtask

  initial
  begin
    repeat (30000) @(posedge clk);
    failures = failures + 1;
    test_done;
  end

  initial
  begin
    // stream, format, aal2/style/crc, range, base, address bytes, length
    rows[0] = {4'h1,3'h1,3'b010,5'h01,16'h1,8'h05,8'h00,4'h3};
    rows[1] = {4'h2,3'h2,3'b111,5'h00,16'h2,8'h01,8'h23,4'h4};
    rows[2] = {4'h3,3'h4,3'b010,5'h1f,16'h0,8'h01,8'hef,4'h2};
    rows[3] = {4'h4,3'h0,3'b110,5'h02,16'h3,8'h00,8'h00,4'h5};
    rows[4] = {4'h5,3'h1,3'b000,5'h01,16'h1,8'h10,8'h00,4'h2};
    rows[5] = {4'h6,3'h1,3'b010,5'h01,16'h0,8'h00,8'h00,4'h1};
    rows[6] = {4'h7,3'h1,3'b101,5'h02,16'h1,8'h0a,8'h00,4'h2};
    rows[7] = {4'h8,3'h2,3'b000,5'h00,16'h0,8'h01,8'h00,4'h3};
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    rd(12'h80c, 32'h1);
    rd(12'h800, 32'h0);
    rd(12'h808, 32'h0);
    rd(12'h900, 32'h0);
    $display("reset test done");
    for (i = 0; i < 8; i = i + 1)
    begin
      r = rows[i];
      cfg(r);
      frame(r);
      addr = r.fmt == 3'b001 ? r.a0 : (r.fmt == 3'b010 || r.fmt == 3'b100)
             ? {r.a0[0], r.a1} : 0;
      idx = r.base * 16 + addr;
      e = addr < (r.rng == 0 ? 512 : r.rng * 16) && idx != 0;
      if (e) nok = nok + 1;
      else ndis = ndis + 1;
      await(e);
      if (e)
      begin
        chk(ssram_addr, r.base * 64 + addr * 4, "lut addr");
        chk(evt_stream, r.s, "stream");
        chk(evt_conn, idx, "conn");
        chk(evt_len, r.n, "length");
        chk({evt_aal2, evt_flush, evt_timeout}, r.opt[2] ?
            {1'b1, idx[1], idx[7:0]} : 10'h0, "cell opts");
        if (!r.opt[2])
          chk(evt_timestamp, idx[0] ? bus_timestamp + pkt_timestamp :
              pkt_timestamp, "timestamp");
      end
      $display("row %0d done", i);
    end
    rd(12'h800, nok);
    rd(12'h804, ndis);
    cfg(rows[0]);
    seq(48'h7e057d5e017e, 6);
    await(1'b1);
    chk(evt_len, 2, "esc len");
    cfg(rows[0]);
    seq(48'h7e05017d7e, 5);
    await(1'b0);
    $display("escape and abort test done");
    wr(12'h80c, 32'h0);
    n0 = n_ev;
    frame(rows[0]);
    await(1'b0);
    wr(12'h80c, 32'h1);
    rd(12'h800, nok + 1);
    $display("enable test done");
    test_done;
  end
endmodule
`default_nettype wire
